// file: rtl/bts_bus_if.sv
// backplane transfer bus between master end and slave end
`timescale 1ns/1ns
interface bts_bus_if;
   // master driven lines
   logic m_as_n;
   logic [1:0] m_ds_n;
   logic m_write_n;
   logic m_lword_n;
   logic [5:0] m_am;
   logic [31:1] m_addr;
   logic m_addr_oe;
   logic [31:0] m_data_out;
   logic [3:0] m_data_oe;
   // slave driven lines
   logic [31:0] s_data_out;
   logic [3:0] s_data_oe;
   logic s_dtack_out;
   logic s_dtack_oe;
   logic s_berr_out;
   logic s_berr_oe;
   // resolved wire levels, undriven lines float high
   logic [31:0] data_in;
   logic dtack_n;
   logic berr_n;

   assign dtack_n = s_dtack_oe ? s_dtack_out : 1'b1;
   assign berr_n = s_berr_oe ? s_berr_out : 1'b1;

   // per byte lane resolution
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign data_in[8*gi +: 8] = m_data_oe[gi] ? m_data_out[8*gi +: 8] :
                                     s_data_oe[gi] ? s_data_out[8*gi +: 8] : 8'hff;
      end
   endgenerate

   modport master (
      output m_as_n, m_ds_n, m_write_n, m_lword_n, m_am, m_addr, m_addr_oe,
      output m_data_out, m_data_oe,
      input data_in, dtack_n, berr_n
   );
   modport slave (
      input m_as_n, m_ds_n, m_write_n, m_lword_n, m_am, m_addr, m_addr_oe,
      output s_data_out, s_data_oe, s_dtack_out, s_dtack_oe, s_berr_out, s_berr_oe,
      input data_in, dtack_n
   );
endinterface : bts_bus_if

// file: rtl/bts_master.sv
// master end: drives single, block and address-only cycles
`timescale 1ns/1ns
module bts_master (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   bts_bus_if.master bus,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_write_i,
   input wire logic cmd_addr_only_i,
   input wire logic cmd_block_i,
   input wire logic [31:0] cmd_addr_i,
   input wire logic [5:0] cmd_am_i,
   input wire logic [2:0] cmd_size_i,
   input wire logic [8:0] cmd_beats_i,
   input wire logic wd_valid_i,
   output logic wd_ready_o,
   input wire logic [31:0] wd_data_i,
   output logic rsp_valid_o,
   output logic rsp_err_o,
   output logic [31:0] rsp_data_o
);
   import bts_pkg::*;

   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_ADDR = 2'b01,
      M_DS = 2'b10,
      M_REL = 2'b11
   } bts_mstate_t;

   bts_mstate_t state_ff;
   logic write_ff;
   logic aonly_ff;
   logic first_ff;
   logic abort_ff;
   logic [2:0] size_ff;
   logic [8:0] left_ff;
   logic [31:0] addr_ff;
   logic as_n_ff;
   logic [1:0] ds_n_ff;
   logic lword_n_ff;
   logic [31:0] wdata_ff;
   logic rsp_valid_ff;
   logic rsp_err_ff;
   logic [31:0] rsp_data_ff;
   logic [5:0] am_ff;
   logic [3:0] lanes;
   logic [1:0] ds_n;
   logic too_long;
   logic go;

   // block length check in bytes
   assign too_long = cmd_block_i && ((cmd_beats_i == 9'h0) ||
                     (12'(cmd_beats_i) * 12'(cmd_size_i) > 12'(BLOCK_MAX_BYTES)));
   assign cmd_ready_o = (state_ff == M_IDLE);
   assign wd_ready_o = (state_ff == M_ADDR) && write_ff && !aonly_ff;
   assign go = (state_ff == M_ADDR) && !aonly_ff && (!write_ff || wd_valid_i);

   // strobes and lanes of the next beat from the running address
   always_comb begin
      lanes = 4'hf;
      ds_n = 2'b00;
      if (size_ff == SIZE_BYTE) begin
         lanes = addr_ff[0] ? 4'h1 : 4'h2;
         ds_n = addr_ff[0] ? 2'b10 : 2'b01;
      end else if (size_ff == SIZE_HALF) begin
         lanes = 4'h3;
      end
   end

   // cycle sequencer
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= M_IDLE;
         as_n_ff <= PIN_IDLE;
         ds_n_ff <= DS_IDLE;
         lword_n_ff <= PIN_IDLE;
         abort_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            M_IDLE: begin
               abort_ff <= 1'b0;
               if (cmd_valid_i && !too_long) begin
                  state_ff <= M_ADDR;
                  as_n_ff <= 1'b0;
               end
            end
            M_ADDR: begin
               if (aonly_ff) begin
                  state_ff <= M_IDLE;
                  as_n_ff <= PIN_IDLE;
               end else if (go) begin
                  state_ff <= M_DS;
                  ds_n_ff <= ds_n;
                  lword_n_ff <= (size_ff != SIZE_WORD);
               end
            end
            M_DS: begin
               if (!bus.dtack_n || !bus.berr_n) begin
                  state_ff <= M_REL;
                  ds_n_ff <= DS_IDLE;
                  abort_ff <= !bus.berr_n;
               end
            end
            M_REL: begin
               if (bus.dtack_n && bus.berr_n) begin
                  if (left_ff != 9'h0 && !abort_ff) begin
                     state_ff <= M_ADDR;
                  end else begin
                     state_ff <= M_IDLE;
                     as_n_ff <= PIN_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // command capture and running block address
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         write_ff <= 1'b0;
         aonly_ff <= 1'b0;
         first_ff <= 1'b0;
         size_ff <= SIZE_BYTE;
         left_ff <= 9'h0;
         addr_ff <= 32'h0;
         am_ff <= 6'h0;
         wdata_ff <= 32'h0;
      end else if (state_ff == M_IDLE && cmd_valid_i) begin
         write_ff <= cmd_write_i;
         aonly_ff <= cmd_addr_only_i;
         first_ff <= 1'b1;
         size_ff <= cmd_size_i;
         left_ff <= cmd_block_i ? cmd_beats_i : 9'h1;
         addr_ff <= cmd_addr_i;
         am_ff <= cmd_am_i;
      end else if (go) begin
         wdata_ff <= wd_data_i;
         left_ff <= left_ff - 9'h1;
      end else if (state_ff == M_DS && !bus.dtack_n) begin
         first_ff <= 1'b0;
         addr_ff <= addr_ff + 32'(size_ff);
      end
   end

   // one response per beat, error on timeout or refused command
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rsp_valid_ff <= 1'b0;
         rsp_err_ff <= 1'b0;
         rsp_data_ff <= 32'h0;
      end else begin
         rsp_valid_ff <= 1'b0;
         if (state_ff == M_IDLE && cmd_valid_i && too_long) begin
            rsp_valid_ff <= 1'b1;
            rsp_err_ff <= 1'b1;
         end else if (state_ff == M_ADDR && aonly_ff) begin
            rsp_valid_ff <= 1'b1;
            rsp_err_ff <= 1'b0;
         end else if (state_ff == M_DS && (!bus.dtack_n || !bus.berr_n)) begin
            rsp_valid_ff <= 1'b1;
            rsp_err_ff <= bus.dtack_n;
            rsp_data_ff <= bus.data_in;
         end
      end
   end

   assign rsp_valid_o = rsp_valid_ff;
   assign rsp_err_o = rsp_err_ff;
   assign rsp_data_o = rsp_data_ff;

   // address and modifier on the lines only until the first beat ends
   assign bus.m_as_n = as_n_ff;
   assign bus.m_ds_n = ds_n_ff;
   assign bus.m_lword_n = lword_n_ff;
   assign bus.m_write_n = !write_ff;
   assign bus.m_addr_oe = first_ff && !as_n_ff;
   assign bus.m_addr = bus.m_addr_oe ? addr_ff[31:1] : 31'h0;
   assign bus.m_am = bus.m_addr_oe ? am_ff : 6'h0;
   assign bus.m_data_out = wdata_ff;
   assign bus.m_data_oe = (state_ff == M_DS && write_ff) ? lanes : 4'h0;
endmodule : bts_master

// file: rtl/bts_pkg.sv
// constants and types shared by both ends of the backplane transfer link
package bts_pkg;
   // address decode capability
   typedef enum logic [1:0] {
      ACAP_SHORT = 2'b00,
      ACAP_STANDARD = 2'b01,
      ACAP_EXTENDED = 2'b10
   } bts_acap_t;

   // data path capability
   typedef enum logic [1:0] {
      DCAP_ODD_BYTE = 2'b00,
      DCAP_EVEN_ODD_BYTE = 2'b01,
      DCAP_HALFWORD = 2'b10,
      DCAP_FULLWORD = 2'b11
   } bts_dcap_t;

   // decoded widths of each address capability
   localparam logic [31:0] SHORT_ADDR_MASK = 32'h0000_ffff;
   localparam logic [31:0] STANDARD_ADDR_MASK = 32'h00ff_ffff;
   localparam logic [31:0] EXTENDED_ADDR_MASK = 32'hffff_ffff;

   // block transfer limit in bytes
   localparam logic [8:0] BLOCK_MAX_BYTES = 9'h100;

   // beat sizes in bytes
   localparam logic [2:0] SIZE_BYTE = 3'h1;
   localparam logic [2:0] SIZE_HALF = 3'h2;
   localparam logic [2:0] SIZE_WORD = 3'h4;

   // bus timer, 20 us, longest time so rounded down
   localparam int CLK_PERIOD_NS = 10;
   localparam int BUS_TIMEOUT_NS = 20000;
   localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int TIMER_W = 12;

   // reset values of master pin drivers (lines idle high)
   localparam logic PIN_IDLE = 1'b1;
   localparam logic [1:0] DS_IDLE = 2'h3;
endpackage : bts_pkg

// file: rtl/bts_slave.sv
// slave end: write fifo, address decode, data lanes and bus timer
`timescale 1ns/1ns
module bts_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wptr_ff;
   logic [AW-1:0] rptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   assign in_ready_o = (count_ff != AW'(0) + (AW+1)'(DEPTH));
   assign out_valid_o = (count_ff != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_ff[rptr_ff];

   // storage has no reset, contents are qualified by count
   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem_ff[wptr_ff] <= in_data_i;
      end
   end

   // pointers wrap at depth, so depth need not be a power of two
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wptr_ff <= (wptr_ff == AW'(DEPTH - 1)) ? '0 : wptr_ff + AW'(1);
         end
         if (pop) begin
            rptr_ff <= (rptr_ff == AW'(DEPTH - 1)) ? '0 : rptr_ff + AW'(1);
         end
         count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : bts_fifo

module bts_slave #(
   parameter bts_pkg::bts_acap_t ADDR_CAP = bts_pkg::ACAP_EXTENDED,
   parameter bts_pkg::bts_dcap_t DATA_CAP = bts_pkg::DCAP_FULLWORD,
   parameter logic [31:0] BASE_ADDR = 32'h0000_0000,
   parameter int WIN_BITS = 12,
   parameter logic [5:0] AM_SINGLE = 6'h01,
   parameter logic [5:0] AM_BLOCK = 6'h02,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   bts_bus_if.slave bus,
   output logic wr_valid_o,
   input wire logic wr_ready_i,
   output logic [31:0] wr_addr_o,
   output logic [3:0] wr_lanes_o,
   output logic [31:0] wr_data_o,
   output logic rd_req_o,
   output logic [31:0] rd_addr_o,
   output logic [3:0] rd_lanes_o,
   input wire logic rd_valid_i,
   input wire logic [31:0] rd_data_i,
   output logic timeout_o
);
   import bts_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_WAIT_DS = 3'b001,
      S_XFER = 3'b010,
      S_ACK = 3'b011,
      S_HOLD = 3'b100,
      S_IGNORE = 3'b101
   } bts_sstate_t;

   bts_sstate_t state_ff;
   logic block_ff;
   logic write_ff;
   logic [31:0] addr_ff;
   logic [31:0] eff_addr_ff;
   logic [3:0] lanes_ff;
   logic [2:0] size_ff;
   logic [8:0] bytes_ff;
   logic [31:0] rdata_ff;
   logic [TIMER_W-1:0] timer_ff;
   logic berr_ff;
   logic ds_any;
   logic hit;
   logic legal;
   logic [3:0] lanes;
   logic [2:0] size;
   logic [31:0] eff_addr;
   logic room;
   logic fifo_in_ready;
   logic [67:0] fifo_out;

   assign ds_any = (bus.m_ds_n != DS_IDLE);

   // address window decode over the lines of the chosen capability
   always_comb begin
      logic [31:0] mask;
      mask = EXTENDED_ADDR_MASK;
      unique case (ADDR_CAP)
         ACAP_SHORT: mask = SHORT_ADDR_MASK;
         ACAP_STANDARD: mask = STANDARD_ADDR_MASK;
         ACAP_EXTENDED: mask = EXTENDED_ADDR_MASK;
         default: mask = EXTENDED_ADDR_MASK;
      endcase
      mask = mask & ~((32'h1 << WIN_BITS) - 32'h1);
      hit = ((({bus.m_addr, 1'b0} ^ BASE_ADDR) & mask) == 32'h0) &&
            ((bus.m_am == AM_SINGLE) || (bus.m_am == AM_BLOCK));
   end

   // lane and size decode, restricted by data capability
   always_comb begin
      lanes = 4'h0;
      size = SIZE_BYTE;
      legal = 1'b0;
      if (bus.m_ds_n == 2'b10) begin
         lanes = 4'h1;
         legal = 1'b1;
      end else if (bus.m_ds_n == 2'b01) begin
         lanes = 4'h2;
         legal = (DATA_CAP != DCAP_ODD_BYTE);
      end else if (bus.m_ds_n == 2'b00 && bus.m_lword_n) begin
         lanes = 4'h3;
         size = SIZE_HALF;
         legal = (DATA_CAP == DCAP_HALFWORD) || (DATA_CAP == DCAP_FULLWORD);
      end else if (bus.m_ds_n == 2'b00) begin
         lanes = 4'hf;
         size = SIZE_WORD;
         legal = (DATA_CAP == DCAP_FULLWORD);
      end
      eff_addr = (size == SIZE_BYTE) ? {addr_ff[31:1], lanes[0]} : addr_ff;
   end

   // a block beat that would pass the byte limit is never acknowledged
   assign room = !block_ff || ((bytes_ff + 9'(size)) <= BLOCK_MAX_BYTES);

   // cycle sequencer
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= S_IDLE;
      end else begin
         unique case (state_ff)
            S_IDLE: begin
               if (!bus.m_as_n) begin
                  state_ff <= hit ? S_WAIT_DS : S_IGNORE;
               end
            end
            S_WAIT_DS: begin
               if (bus.m_as_n) begin
                  state_ff <= S_IDLE;
               end else if (ds_any) begin
                  state_ff <= (legal && room) ? S_XFER : S_HOLD;
               end
            end
            S_XFER: begin
               if (berr_ff) begin
                  state_ff <= S_HOLD;
               end else if (write_ff ? fifo_in_ready : rd_valid_i) begin
                  state_ff <= S_ACK;
               end
            end
            S_ACK, S_HOLD: begin
               if (!ds_any) begin
                  state_ff <= bus.m_as_n ? S_IDLE : (block_ff ? S_WAIT_DS : S_IGNORE);
               end
            end
            S_IGNORE: begin
               if (bus.m_as_n) begin
                  state_ff <= S_IDLE;
               end
            end
            default: state_ff <= S_IDLE;
         endcase
      end
   end

   // captured address, modifier and block byte count
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr_ff <= 32'h0;
         block_ff <= 1'b0;
         bytes_ff <= 9'h0;
      end else if (state_ff == S_IDLE && !bus.m_as_n) begin
         addr_ff <= {bus.m_addr, 1'b0};
         block_ff <= (bus.m_am == AM_BLOCK);
         bytes_ff <= 9'h0;
      end else if (state_ff == S_ACK && !ds_any && block_ff) begin
         addr_ff <= eff_addr_ff + 32'(size_ff);
         bytes_ff <= bytes_ff + 9'(size_ff);
      end
   end

   // per beat lanes, direction and effective address
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         write_ff <= 1'b0;
         lanes_ff <= 4'h0;
         size_ff <= SIZE_BYTE;
         eff_addr_ff <= 32'h0;
      end else if (state_ff == S_WAIT_DS && ds_any) begin
         write_ff <= !bus.m_write_n;
         lanes_ff <= lanes;
         size_ff <= size;
         eff_addr_ff <= eff_addr;
      end
   end

   // read data is held in a register while acknowledged
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff <= 32'h0;
      end else if (state_ff == S_XFER && !write_ff && rd_valid_i) begin
         rdata_ff <= rd_data_i;
      end
   end

   // bus timer restarts whenever the strobes go away
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_ff <= '0;
         berr_ff <= 1'b0;
      end else if (!ds_any) begin
         timer_ff <= '0;
         berr_ff <= 1'b0;
      end else if ((bus.dtack_n || berr_ff) && timer_ff != TIMER_W'(BUS_TIMEOUT_CYC + 1)) begin
         if (timer_ff == TIMER_W'(BUS_TIMEOUT_CYC - 1)) begin
            berr_ff <= 1'b1;
         end
         timer_ff <= timer_ff + TIMER_W'(1);
      end
   end

   assign timeout_o = berr_ff && (timer_ff == TIMER_W'(BUS_TIMEOUT_CYC)); // one extra count: pulse

   // bus drivers: data only on lanes of the current beat and only when acknowledged, bus error whenever the timer has fired
   assign bus.s_dtack_out = 1'b0;
   assign bus.s_dtack_oe = (state_ff == S_ACK);
   assign bus.s_berr_out = 1'b0;
   assign bus.s_berr_oe = berr_ff;
   assign bus.s_data_out = rdata_ff;
   assign bus.s_data_oe = (state_ff == S_ACK && !write_ff) ? lanes_ff : 4'h0;

   // read request toward the local store
   assign rd_req_o = (state_ff == S_XFER) && !write_ff && !berr_ff;
   assign rd_addr_o = eff_addr_ff;
   assign rd_lanes_o = lanes_ff;

   // written beats queue here so a slow local store stalls the acknowledge only once the fifo is full
   bts_fifo #(
      .WIDTH(68),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i((state_ff == S_XFER) && write_ff && !berr_ff),
      .in_ready_o(fifo_in_ready),
      .in_data_i({eff_addr_ff, lanes_ff, bus.data_in}),
      .out_valid_o(wr_valid_o),
      .out_ready_i(wr_ready_i),
      .out_data_o(fifo_out)
   );

   assign wr_addr_o = fifo_out[67:36];
   assign wr_lanes_o = fifo_out[35:32];
   assign wr_data_o = fifo_out[31:0];
endmodule : bts_slave

// file: testbench/backplane_transfer_slave_test.sv
// master and slave ends joined back to back, random and corner traffic
`timescale 1ns/1ns
module backplane_transfer_slave_test;
   import bts_pkg::*;
   localparam logic [31:0] BASE = 32'ha000_0000;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, fill = 1'b0, rd_hold = 1'b0;
   logic cmd_valid_i = 1'b0, cmd_write_i = 1'b0, cmd_addr_only_i = 1'b0, cmd_block_i = 1'b0;
   logic [31:0] cmd_addr_i = 32'h0, wd_data_i = 32'h0, rd_data_i = 32'h0;
   logic [31:0] rnd = 32'h6b809130, rr = 32'h6b809130;
   logic [5:0] cmd_am_i = 6'h01;
   logic [2:0] cmd_size_i = 3'h4;
   logic [8:0] cmd_beats_i = 9'h001;
   logic wr_ready_i = 1'b0, rd_valid_i = 1'b0, wd_valid_i = 1'b0;
   logic cmd_ready_o, wd_ready_o, rsp_valid_o, rsp_err_o, wr_valid_o, rd_req_o, timeout_o;
   logic [31:0] rsp_data_o, wr_addr_o, wr_data_o, rd_addr_o;
   logic [3:0] wr_lanes_o, rd_lanes_o;
   logic [35:0] exp_w[$], exp_r[$];
   logic [31:0] exp_d[$];
   int error_cnt = 0, samples_checked = 0, cycles = 0, to_cnt = 0, rd_wait = 0;

   bts_bus_if bts_bus_if_inst ();
   bts_master bts_master_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bts_bus_if_inst),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i),
      .cmd_addr_only_i(cmd_addr_only_i), .cmd_block_i(cmd_block_i), .cmd_addr_i(cmd_addr_i),
      .cmd_am_i(cmd_am_i), .cmd_size_i(cmd_size_i), .cmd_beats_i(cmd_beats_i),
      .wd_valid_i(wd_valid_i), .wd_ready_o(wd_ready_o), .wd_data_i(wd_data_i),
      .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o), .rsp_data_o(rsp_data_o));
   bts_slave #(.BASE_ADDR(BASE), .WIN_BITS(12), .FIFO_DEPTH(8)) bts_slave_inst (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bts_bus_if_inst), .wr_valid_o(wr_valid_o),
      .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o), .wr_lanes_o(wr_lanes_o),
      .wr_data_o(wr_data_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o),
      .rd_lanes_o(rd_lanes_o), .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i),
      .timeout_o(timeout_o));
   bts_link_props #(.BASE_ADDR(BASE), .WIN_BITS(12)) bts_link_props_inst (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .m_as_n(bts_bus_if_inst.m_as_n),
      .m_ds_n(bts_bus_if_inst.m_ds_n), .m_write_n(bts_bus_if_inst.m_write_n),
      .m_lword_n(bts_bus_if_inst.m_lword_n), .m_am(bts_bus_if_inst.m_am),
      .m_addr(bts_bus_if_inst.m_addr), .s_data_oe(bts_bus_if_inst.s_data_oe),
      .s_dtack_oe(bts_bus_if_inst.s_dtack_oe), .berr_n(bts_bus_if_inst.berr_n));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   // read data made from the address, so misaddressed beats show up
   function automatic logic [31:0] rdf(input logic [31:0] a);
      return {a[15:0] ^ 16'h3c5a, ~a[15:0]};
   endfunction : rdf
   function automatic logic [3:0] lanes(input logic [31:0] a, input logic [2:0] sz);
      return sz == SIZE_WORD ? 4'hf : sz == SIZE_HALF ? 4'h3 : a[0] ? 4'h1 : 4'h2;
   endfunction : lanes
   function automatic logic [31:0] bmask(input logic [3:0] l);
      return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
   endfunction : bmask

   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   // one command, then one response per beat; beat k sits at a + k*sz
   task automatic xfer(input logic wr, ao, blk, input logic [31:0] a, input logic [2:0] sz,
                       input logic [8:0] nb, input logic err);
      int n;
      logic [31:0] ba, m;
      n = (ao || err || !blk) ? 1 : int'(nb);
      for (int k = 0; k < n; k++) begin
         ba = a + 32'(k) * 32'(sz);
         if (!err && !ao && wr) exp_w.push_back({lanes(ba, sz), ba});
         if (!err && !ao && !wr) exp_r.push_back({lanes(ba, sz), ba});
      end
      cmd_write_i = wr;
      cmd_addr_only_i = ao;
      cmd_block_i = blk;
      cmd_addr_i = a;
      cmd_am_i = blk ? 6'h02 : 6'h01;
      cmd_size_i = sz;
      cmd_beats_i = nb;
      cmd_valid_i = 1'b1;
      while (!cmd_ready_o) begin @(posedge mclk_i); #1; end
      @(posedge mclk_i);
      #1;
      cmd_valid_i = 1'b0;
      for (int k = 0; k < n; k++) begin
         while (!rsp_valid_o) begin @(posedge mclk_i); #1; end
         ba = a + 32'(k) * 32'(sz);
         m = bmask(lanes(ba, sz));
         check(rsp_err_o, err);
         if (!wr && !ao && !err) check(rsp_data_o & m, rdf(ba) & m);
         @(posedge mclk_i);
         #1;
      end
      if (err && wr) void'(exp_d.pop_back());
   endtask : xfer

   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   // user side of the slave plus the hang guard; backpressure and read delay vary
   initial begin
      forever begin
         @(posedge mclk_i);
         #1;
         cycles++;
         if (cycles > 40000) begin
            error_cnt++;
            tally_and_finish();
         end
         rnd = lfsr(rnd);
         wd_data_i = rnd;
         wd_valid_i = rnd[6] | rnd[7];
         wr_ready_i = !fill && rnd[3];
         rd_valid_i = 1'b0;
         if (!rd_req_o) rd_hold = 1'b0;
         else if (!rd_hold && rd_wait > 0) rd_wait--;
         else if (!rd_hold) begin
            rd_valid_i = 1'b1;
            rd_data_i = rdf(rd_addr_o);
            check({rd_lanes_o, rd_addr_o}, exp_r.pop_front());
            rd_hold = 1'b1;
            rd_wait = int'(rnd[5:4]);
         end
      end
   end

   // handshakes judged on pre-edge values
   always @(posedge mclk_i) begin : mon
      logic [35:0] w;
      logic [31:0] d;
      if (wd_valid_i && wd_ready_o) exp_d.push_back(wd_data_i);
      if (timeout_o) to_cnt++;
      if (wr_valid_o && wr_ready_i) begin
         w = exp_w.pop_front();
         d = exp_d.pop_front();
         check({wr_lanes_o, wr_addr_o}, w);
         check(wr_data_o & bmask(w[35:32]), d & bmask(w[35:32]));
      end
   end

   initial begin : main
      logic [2:0] sz;
      logic [31:0] a;
      repeat (8) @(posedge mclk_i);
      #1;
      rst_n_i = 1'b1;
      check({bts_bus_if_inst.s_dtack_oe, bts_bus_if_inst.s_data_oe, rd_req_o}, 36'h0);
      xfer(1'b0, 1'b1, 1'b0, BASE + 32'h10, SIZE_WORD, 9'h001, 1'b0);
      xfer(1'b0, 1'b0, 1'b1, BASE, SIZE_WORD, 9'h000, 1'b1);
      xfer(1'b0, 1'b0, 1'b1, BASE, SIZE_WORD, 9'h041, 1'b1);
      xfer(1'b0, 1'b0, 1'b1, BASE + 32'h100, SIZE_WORD, 9'h040, 1'b0);
      xfer(1'b1, 1'b0, 1'b1, BASE, SIZE_BYTE, 9'h100, 1'b0);
      xfer(1'b0, 1'b0, 1'b1, BASE + 32'h07, SIZE_BYTE, 9'h005, 1'b0);
      xfer(1'b0, 1'b0, 1'b1, BASE + 32'h42, SIZE_HALF, 9'h007, 1'b0);
      $display("test corners done");
      for (int i = 0; i < 40; i++) begin
         rr = lfsr(rr);
         sz = rr[1:0] == 2'b00 ? SIZE_BYTE : rr[1] ? SIZE_WORD : SIZE_HALF;
         a = BASE + ({21'h0, rr[18:8]} & ~(32'(sz) - 32'h1));
         xfer(rr[2], 1'b0, rr[3], a, sz, {5'h00, rr[7:4]} + 9'h001, 1'b0);
      end
      $display("test random done");
      xfer(1'b0, 1'b0, 1'b0, BASE ^ 32'h8000_0000, SIZE_WORD, 9'h001, 1'b1);
      check(36'(to_cnt), 36'h1);
      $display("test unselected done");
      // full fifo holds off the acknowledge until the timer ends the beat
      fill <= 1'b1;
      for (int i = 0; i < 9; i++)
         xfer(1'b1, 1'b0, 1'b0, BASE + 32'h200 + 32'(4 * i), SIZE_WORD, 9'h001, i == 8);
      check(36'(to_cnt), 36'h2);
      fill <= 1'b0;
      for (int i = 0; i < 200 && exp_w.size() > 0; i++) @(posedge mclk_i);
      #2;
      check({wr_valid_o, 35'(exp_w.size())}, 36'h0);
      $display("test fifo done");
      tally_and_finish();
   end
endmodule : backplane_transfer_slave_test

// file: testbench/bts_link_props.sv
// wire-level checks between the master end and the slave end
`timescale 1ns/1ns
module bts_link_props
   import bts_pkg::*;
#(
   parameter logic [31:0] BASE_ADDR = 32'h0000_0000,
   parameter int WIN_BITS = 12,
   parameter logic [5:0] AM_SINGLE = 6'h01,
   parameter logic [5:0] AM_BLOCK = 6'h02
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic m_as_n,
   input wire logic [1:0] m_ds_n,
   input wire logic m_write_n,
   input wire logic m_lword_n,
   input wire logic [5:0] m_am,
   input wire logic [31:1] m_addr,
   input wire logic [3:0] s_data_oe,
   input wire logic s_dtack_oe,
   input wire logic berr_n
);
   localparam int LATE = BUS_TIMEOUT_CYC;
   localparam int EARLY = BUS_TIMEOUT_CYC - 4;
   logic as_q_ff;
   logic unsel_ff;
   int cnt_ff;
   logic sel;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   // decode match, only meaningful while the address is on the wires
   assign sel = (m_addr[31:WIN_BITS] == BASE_ADDR[31:WIN_BITS]) &&
                (m_am == AM_SINGLE || m_am == AM_BLOCK);

   // latch a miss at the strobe's falling edge; later beats carry no address
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         as_q_ff <= 1'b1;
         unsel_ff <= 1'b0;
      end else begin
         as_q_ff <= m_as_n;
         if (m_as_n)
            unsel_ff <= 1'b0;
         else if (as_q_ff && !sel)
            unsel_ff <= 1'b1;
      end
   end

   // strobe time without an answer, cleared between beats
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         cnt_ff <= 0;
      else if (m_ds_n == 2'b11)
         cnt_ff <= 0;
      else if (!s_dtack_oe && cnt_ff < 4095)
         cnt_ff <= cnt_ff + 1;
   end

   // address strobe for one cycle with no data strobe
   sequence s_addr_only;
      $fell(m_as_n) && m_ds_n == 2'b11 ##1 m_as_n && m_ds_n == 2'b11;
   endsequence
   sequence s_rd_ack;
      $rose(s_dtack_oe) && m_write_n;
   endsequence

   a_addr_only_quiet: assert property (s_addr_only |-> !s_dtack_oe [*3])
      else $error("acknowledge on an address-only cycle");
   a_ack_after_strobe: assert property ($rose(s_dtack_oe) |-> !m_as_n && $past(m_ds_n) != 2'b11)
      else $error("acknowledge without a data strobe");
   a_ack_hold: assert property (s_dtack_oe && m_ds_n != 2'b11 |=> s_dtack_oe)
      else $error("acknowledge dropped while a strobe is low");
   a_unsel_quiet: assert property (unsel_ff |-> !s_dtack_oe && s_data_oe == 4'h0)
      else $error("unselected cycle drives the bus");
   a_timer_fires: assert property (cnt_ff == LATE |-> ##[0:4] !berr_n)
      else $error("bus timer did not end the transfer");
   a_timer_early: assert property (m_ds_n != 2'b11 && cnt_ff > 0 && cnt_ff < EARLY |-> berr_n)
      else $error("bus timer fired early");
   a_read_word_lanes: assert property ((s_rd_ack and !m_lword_n) |-> s_data_oe == 4'hf)
      else $error("fullword read lanes wrong");
   a_read_byte_lanes: assert property ((s_rd_ack and (m_lword_n && m_ds_n != 2'b00)) |->
                                       s_data_oe == {2'b00, ~m_ds_n})
      else $error("byte read lane wrong");
   a_write_no_drive: assert property (!m_write_n |-> s_data_oe == 4'h0)
      else $error("slave drives data on a write");
endmodule : bts_link_props
